// [rtl/lpmc_cfg.svh]
/*
 constants for the low-power mode controller: mode codes, ram sizes, defaults.
 assumes inclusion by bare name from design files.
*/
`ifndef LPMC_CFG_SVH
`define LPMC_CFG_SVH
`define LPMC_MODE_W 3
`define LPMC_SEL_STATIC 3'h0
`define LPMC_SEL_RET_UP 3'h1
`define LPMC_SEL_RET_LO 3'h2
`define LPMC_SEL_LK_FULL 3'h3
`define LPMC_SEL_LK_PART 3'h4
`define LPMC_SEL_LK_NORAM 3'h5
`define LPMC_SEL_LK_DEEP 3'h6
`define LPMC_RAM_16K_KB 16
`define LPMC_RAM_32K_KB 32
`define LPMC_REGFILE_BYTES 32
`endif

// [rtl/lpmc_pkg.sv]
/*
 types for the low-power mode controller.
 assumes lpmc_cfg.svh is on the include path.
*/
package lpmc_pkg;
   // power and recovery settings applied while asleep
   typedef struct packed {
      logic cpu_halt;
      logic lvd_en;
      logic bias_en;
      logic adc_pin_irq_en;
      logic periph_avail;
      logic wakeup_unit_en;
      logic ram_full;
      logic ram_partial;
      logic ram_part_32k;
      logic regfile_on;
      logic radio_retain;
      logic radio_gated;
      logic radio_dsm_en;
      logic pmc_analog_en;
      logic lpo_en;
      logic io_hold;
      logic bod_en;
      logic pin_wake_only;
      logic wake_by_reset;
   } lpmc_ctrl_type;
   typedef enum logic [1:0] {LPMC_RUN, LPMC_WAIT, LPMC_STOP} lpmc_state_type;
endpackage

// [rtl/lpmc_ctrl.sv]
/*
 low-power mode controller: latches a selected stop mode and applies its
 retention, gating and recovery settings atomically on sleep entry.
 assumes processor sleep and wake strobes are synchronous to i_sys_clk.
*/
// Functional notes
// - static stop halts the processor and turns low-voltage detect off.
// - static stop keeps adc and pin interrupts and low-power peripherals alive.
// - with the converter in continuous operation biasing is off in reduced run, in wait entered from reduced run, and in static stop.
// - both retention stops keep radio logic state, the wakeup unit and peripherals, and wake by interrupt.
// - the lower retention stop keeps a 16 KB or 32 KB ram part powered.
// - full-ram leakage stop keeps all sram and radio state and wakes by reset.
// - partial-ram leakage stop keeps a 16 KB or 32 KB ram part and radio state and wakes by reset.
// - while radio logic is retained the radio deep-sleep logic may run on the 32 kHz clock.
// - no-ram leakage stop powers off sram, keeps the 32-byte register file and gates the radio.
// - from no-ram leakage stop downward the radio state is lost and the radio unavailable.
// - deepest stop turns off power analog and the oscillator, holds io and flops, wakes on pins only.
// - deepest stop exists with brown-out detection on and with it off.
// - the sleep instruction enters wait or stop according to the deep-sleep select bit.
`include "lpmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl
#(
   // selection code width and retained sizes
   parameter int MODE_W = `LPMC_MODE_W,
   parameter int RAM_PART_SMALL_KB = `LPMC_RAM_16K_KB,
   parameter int RAM_PART_LARGE_KB = `LPMC_RAM_32K_KB,
   parameter int REGFILE_BYTES = `LPMC_REGFILE_BYTES
)
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // mode selection from software
   input wire logic [2:0] i_stop_sel,
   input wire logic i_ram_part_32k,
   input wire logic i_deep_bod_en,
   input wire logic i_deep_sleep_select,
   input wire logic i_reduced_speed_run,
   input wire logic i_dcdc_continuous,
   input wire logic i_dcdc_bypass,
   // processor sleep handshake
   input wire logic i_wait_for_interrupt_instr,
   input wire logic i_wake_irq,
   input wire logic i_wake_pin,
   // applied settings and status
   output lpmc_pkg::lpmc_ctrl_type o_ctrl,
   output lpmc_pkg::lpmc_state_type o_state,
   output logic o_wakeup_reset,
   output logic o_radio_lost,
   output logic o_sel_refused
);
   // elaboration checks: the mode decode below serves only these values
   if (MODE_W != 3)
   begin : g_bad_mode_w
      $error("lpmc_ctrl: MODE_W must be 3");
   end
   if ((RAM_PART_SMALL_KB != 16) || (RAM_PART_LARGE_KB != 32))
   begin : g_bad_ram_part
      $error("lpmc_ctrl: partial ram sizes must be 16 and 32 KB");
   end
   if (REGFILE_BYTES != 32)
   begin : g_bad_regfile
      $error("lpmc_ctrl: register file must be 32 bytes");
   end

   // run-time settings used outside sleep
   function automatic lpmc_pkg::lpmc_ctrl_type run_ctrl(input logic reduced, input logic cont);
      lpmc_pkg::lpmc_ctrl_type c;
      c = '0;
      c.lvd_en = !reduced;
      c.bias_en = !(reduced && cont);
      c.adc_pin_irq_en = 1'b1;
      c.periph_avail = 1'b1;
      c.ram_full = 1'b1;
      c.regfile_on = 1'b1;
      c.pmc_analog_en = 1'b1;
      c.lpo_en = 1'b1;
      c.io_hold = 1'b1;
      c.bod_en = 1'b1;
      return c;
   endfunction

   // per stop mode settings
   function automatic lpmc_pkg::lpmc_ctrl_type stop_ctrl(input logic [2:0] sel, input logic p32,
                                                         input logic bod, input logic cont);
      lpmc_pkg::lpmc_ctrl_type c;
      c = '0;
      c.cpu_halt = 1'b1;
      c.io_hold = 1'b1;
      c.regfile_on = 1'b1;
      c.pmc_analog_en = 1'b1;
      c.lpo_en = 1'b1;
      c.bod_en = 1'b1;
      c.periph_avail = 1'b1;
      c.bias_en = 1'b1;
      case (sel)
         `LPMC_SEL_STATIC:
         begin
            c.lvd_en = 1'b0;
            c.adc_pin_irq_en = 1'b1;
            c.ram_full = 1'b1;
            c.bias_en = !cont;
         end
         `LPMC_SEL_RET_UP, `LPMC_SEL_RET_LO:
         begin
            c.wakeup_unit_en = 1'b1;
            c.radio_retain = 1'b1;
            c.radio_dsm_en = 1'b1;
            c.ram_full = (sel == `LPMC_SEL_RET_UP);
            c.ram_partial = (sel == `LPMC_SEL_RET_LO);
            c.ram_part_32k = (sel == `LPMC_SEL_RET_LO) && p32;
         end
         `LPMC_SEL_LK_FULL, `LPMC_SEL_LK_PART:
         begin
            c.wakeup_unit_en = 1'b1;
            c.radio_retain = 1'b1;
            c.radio_dsm_en = 1'b1;
            c.ram_full = (sel == `LPMC_SEL_LK_FULL);
            c.ram_partial = (sel == `LPMC_SEL_LK_PART);
            c.ram_part_32k = (sel == `LPMC_SEL_LK_PART) && p32;
            c.wake_by_reset = 1'b1;
         end
         `LPMC_SEL_LK_NORAM:
         begin
            c.wakeup_unit_en = 1'b1;
            c.radio_gated = 1'b1;
            c.wake_by_reset = 1'b1;
         end
         default:
         begin
            c.periph_avail = 1'b0;
            c.pmc_analog_en = 1'b0;
            c.lpo_en = 1'b0;
            c.radio_gated = 1'b1;
            c.pin_wake_only = 1'b1;
            c.bod_en = bod;
            c.wake_by_reset = 1'b1;
         end
      endcase
      return c;
   endfunction

   // sleep state and the settings applied in it
   lpmc_pkg::lpmc_state_type state;
   lpmc_pkg::lpmc_state_type next_state;
   lpmc_pkg::lpmc_ctrl_type next_ctrl;
   logic next_wakeup_reset;
   // latched selection, frozen while asleep
   logic [2:0] sel;
   logic [2:0] next_sel;
   logic p32;
   logic next_p32;
   logic bod;
   logic next_bod;
   logic next_refused;
   // sticky radio state loss
   logic next_radio_lost;
   // decoded strobes
   logic wake;
   logic sel_bad;
   logic enter_stop;
   logic enter_wait;
   logic leave_stop;

   // any wake source; deepest stop narrows this to pins
   assign wake = i_wake_irq || i_wake_pin;
   // deepest stop needs bypass; otherwise fall back to no-ram stop
   assign sel_bad = (i_stop_sel > `LPMC_SEL_LK_DEEP) ||
                    ((i_stop_sel == `LPMC_SEL_LK_DEEP) && !i_dcdc_bypass);
   // sleep instruction honoured only while running
   assign enter_stop = (state == lpmc_pkg::LPMC_RUN) && i_wait_for_interrupt_instr && i_deep_sleep_select;
   assign enter_wait = (state == lpmc_pkg::LPMC_RUN) && i_wait_for_interrupt_instr && !i_deep_sleep_select;
   // deepest stop leaves on pins only, the other stops on any source
   assign leave_stop = (state == lpmc_pkg::LPMC_STOP) && (o_ctrl.pin_wake_only ? i_wake_pin : wake);

   // selection: follows software while running, frozen while asleep
   always_comb
   begin
      next_sel = sel;
      next_p32 = p32;
      next_bod = bod;
      next_refused = o_sel_refused;
      if (state == lpmc_pkg::LPMC_RUN)
      begin
         next_sel = sel_bad ? `LPMC_SEL_LK_NORAM : i_stop_sel;
         next_p32 = i_ram_part_32k;
         next_bod = i_deep_bod_en;
         next_refused = sel_bad;
      end
   end

   // selection registers
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         sel <= `LPMC_SEL_STATIC;
         p32 <= 1'b0;
         bod <= 1'b1;
         o_sel_refused <= 1'b0;
      end
      else
      begin
         sel <= next_sel;
         p32 <= next_p32;
         bod <= next_bod;
         o_sel_refused <= next_refused;
      end
   end

   // sleep state machine; settings swap in one edge so no mix is ever seen
   always_comb
   begin
      next_state = state;
      next_ctrl = o_ctrl;
      next_wakeup_reset = 1'b0;
      case (state)
         lpmc_pkg::LPMC_RUN:
         begin
            next_ctrl = run_ctrl(i_reduced_speed_run, i_dcdc_continuous);
            if (enter_stop)
            begin
               next_state = lpmc_pkg::LPMC_STOP;
               next_ctrl = stop_ctrl(sel, p32, bod, i_dcdc_continuous);
            end
            else if (enter_wait)
            begin
               next_state = lpmc_pkg::LPMC_WAIT;
               next_ctrl.cpu_halt = 1'b1;
            end
         end
         lpmc_pkg::LPMC_WAIT:
         begin
            if (wake)
            begin
               next_state = lpmc_pkg::LPMC_RUN;
               next_ctrl.cpu_halt = 1'b0;
            end
         end
         default:
         begin
            if (leave_stop)
            begin
               next_state = lpmc_pkg::LPMC_RUN;
               next_ctrl = run_ctrl(i_reduced_speed_run, i_dcdc_continuous);
               next_wakeup_reset = o_ctrl.wake_by_reset;
            end
         end
      endcase
   end

   // sleep state registers
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         state <= lpmc_pkg::LPMC_RUN;
         o_ctrl <= run_ctrl(1'b0, 1'b0);
         o_wakeup_reset <= 1'b0;
      end
      else
      begin
         state <= next_state;
         o_ctrl <= next_ctrl;
         o_wakeup_reset <= next_wakeup_reset;
      end
   end

   // radio loss: set on entry to no-ram stop or deeper, kept until reset
   always_comb
   begin
      next_radio_lost = o_radio_lost;
      if (enter_stop && (sel >= `LPMC_SEL_LK_NORAM))
      begin
         next_radio_lost = 1'b1;
      end
   end

   // radio loss register
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         o_radio_lost <= 1'b0;
      end
      else
      begin
         o_radio_lost <= next_radio_lost;
      end
   end

   assign o_state = state;
endmodule // lpmc_ctrl
`default_nettype wire

// [verification/lpmc_ctrl_monitor.sv]
/*
 checker for lpmc_ctrl: stop entry, per-mode settings and wake recovery.
 assumes it is bound to lpmc_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_cfg.svh"
module lpmc_ctrl_monitor
(
   // clock, reset and selection
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic [2:0] i_stop_sel,
   input wire logic i_deep_sleep_select,
   input wire logic i_dcdc_continuous,
   input wire logic i_dcdc_bypass,
   // sleep handshake
   input wire logic i_wait_for_interrupt_instr,
   input wire logic i_wake_irq,
   input wire logic i_wake_pin,
   // applied settings and status
   input wire lpmc_pkg::lpmc_ctrl_type o_ctrl,
   input wire lpmc_pkg::lpmc_state_type o_state,
   input wire logic o_wakeup_reset,
   input wire logic o_radio_lost,
   input wire logic o_sel_refused
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   // stop entry taken in run with mode m registered the cycle before
   sequence s_enter(logic [2:0] m);
      $past(o_state) == lpmc_pkg::LPMC_RUN && o_state == lpmc_pkg::LPMC_RUN && i_wait_for_interrupt_instr
         && i_deep_sleep_select && $past(i_stop_sel) == m;
   endsequence
   // wake strobe taken and pulse released
   sequence s_rst_wake;
      o_state == lpmc_pkg::LPMC_RUN && o_wakeup_reset ##1 !o_wakeup_reset;
   endsequence
   property p_wait;
      o_state == lpmc_pkg::LPMC_RUN && i_wait_for_interrupt_instr && !i_deep_sleep_select
         |=> o_state == lpmc_pkg::LPMC_WAIT && o_ctrl.cpu_halt;
   endproperty
   a_wait: assert property (p_wait) else $error("wait entry wrong");
   property p_static;
      s_enter(`LPMC_SEL_STATIC) |=> o_ctrl.cpu_halt && !o_ctrl.lvd_en && o_ctrl.adc_pin_irq_en && !o_ctrl.wake_by_reset;
   endproperty
   a_static: assert property (p_static) else $error("static stop settings wrong");
   property p_bias;
      s_enter(`LPMC_SEL_STATIC) ##0 i_dcdc_continuous |=> !o_ctrl.bias_en;
   endproperty
   a_bias: assert property (p_bias) else $error("bias left on");
   property p_ret_lo;
      s_enter(`LPMC_SEL_RET_LO) |=> o_ctrl.ram_partial && o_ctrl.radio_retain && o_ctrl.wakeup_unit_en && !o_ctrl.wake_by_reset;
   endproperty
   a_ret_lo: assert property (p_ret_lo) else $error("lower retention settings wrong");
   property p_full;
      s_enter(`LPMC_SEL_LK_FULL) |=> o_ctrl.ram_full && o_ctrl.radio_retain && o_ctrl.wake_by_reset;
   endproperty
   a_full: assert property (p_full) else $error("full ram stop settings wrong");
   property p_noram;
      s_enter(`LPMC_SEL_LK_NORAM) |=> o_ctrl.radio_gated && o_ctrl.regfile_on && !o_ctrl.ram_full && o_radio_lost;
   endproperty
   a_noram: assert property (p_noram) else $error("no ram stop settings wrong");
   property p_deep;
      s_enter(`LPMC_SEL_LK_DEEP) ##0 i_dcdc_bypass |=> !o_ctrl.pmc_analog_en && !o_ctrl.lpo_en && o_ctrl.io_hold;
   endproperty
   a_deep: assert property (p_deep) else $error("deepest stop settings wrong");
   property p_refuse;
      s_enter(`LPMC_SEL_LK_DEEP) ##0 !i_dcdc_bypass |=> o_sel_refused && o_ctrl.radio_gated && !o_ctrl.pin_wake_only;
   endproperty
   a_refuse: assert property (p_refuse) else $error("deepest without bypass not refused");
   property p_pin_only;
      o_state == lpmc_pkg::LPMC_STOP && o_ctrl.pin_wake_only && !i_wake_pin |=> o_state == lpmc_pkg::LPMC_STOP;
   endproperty
   a_pin_only: assert property (p_pin_only) else $error("deepest stop left without pin");
   property p_wake_rst;
      o_state == lpmc_pkg::LPMC_STOP && o_ctrl.wake_by_reset && !o_ctrl.pin_wake_only && i_wake_irq |=> s_rst_wake;
   endproperty
   a_wake_rst: assert property (p_wake_rst) else $error("wakeup reset pulse wrong");
   property p_lost;
      o_radio_lost |=> o_radio_lost;
   endproperty
   a_lost: assert property (p_lost) else $error("radio lost flag dropped");
endmodule // lpmc_ctrl_monitor
bind lpmc_ctrl lpmc_ctrl_monitor u_lpmc_ctrl_monitor (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_stop_sel(i_stop_sel),
   .i_deep_sleep_select(i_deep_sleep_select), .i_dcdc_continuous(i_dcdc_continuous), .i_dcdc_bypass(i_dcdc_bypass),
   .i_wait_for_interrupt_instr(i_wait_for_interrupt_instr), .i_wake_irq(i_wake_irq), .i_wake_pin(i_wake_pin),
   .o_ctrl(o_ctrl), .o_state(o_state), .o_wakeup_reset(o_wakeup_reset), .o_radio_lost(o_radio_lost),
   .o_sel_refused(o_sel_refused));
`default_nettype wire

// [verification/lpmc_ctrl_tb.sv]
/*
 self-checking bench for lpmc_ctrl: every stop mode, wait, refusal, resets.
 assumes inputs change on the falling edge of a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) tests_run++; if ((a) !== (e)) begin $display("ERROR %s exp %0h got %0h", n, e, a); failures++; end
module lpmc_ctrl_tb;
   logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_ram_part_32k = 1'b0, i_deep_bod_en = 1'b0, i_deep_sleep_select = 1'b0;
   logic i_reduced_speed_run = 1'b0, i_dcdc_continuous = 1'b0, i_dcdc_bypass = 1'b0;
   logic i_wait_for_interrupt_instr = 1'b0, i_wake_irq = 1'b0, i_wake_pin = 1'b0;
   logic [2:0] i_stop_sel = 3'h0;
   lpmc_pkg::lpmc_ctrl_type o_ctrl;
   lpmc_pkg::lpmc_state_type o_state;
   logic o_wakeup_reset, o_radio_lost, o_sel_refused;
   int failures = 0;
   int tests_run = 0;
   // device under test
   lpmc_ctrl u_lpmc_ctrl (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_stop_sel(i_stop_sel),
      .i_ram_part_32k(i_ram_part_32k), .i_deep_bod_en(i_deep_bod_en), .i_deep_sleep_select(i_deep_sleep_select),
      .i_reduced_speed_run(i_reduced_speed_run), .i_dcdc_continuous(i_dcdc_continuous),
      .i_dcdc_bypass(i_dcdc_bypass), .i_wait_for_interrupt_instr(i_wait_for_interrupt_instr),
      .i_wake_irq(i_wake_irq), .i_wake_pin(i_wake_pin), .o_ctrl(o_ctrl), .o_state(o_state),
      .o_wakeup_reset(o_wakeup_reset), .o_radio_lost(o_radio_lost), .o_sel_refused(o_sel_refused));
   // clock
   initial
   begin
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   task close_out;
      if (failures == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // select, hold a cycle, pulse the sleep instruction
   task go(input logic [2:0] s, input logic d);
      i_stop_sel = s;
      i_deep_sleep_select = d;
      @(negedge i_sys_clk);
      i_wait_for_interrupt_instr = 1'b1;
      @(negedge i_sys_clk);
      i_wait_for_interrupt_instr = 1'b0;
   endtask
   // one-cycle wake strobe
   task wake(input logic irq, input logic pin);
      i_wake_irq = irq;
      i_wake_pin = pin;
      @(negedge i_sys_clk);
      i_wake_irq = 1'b0;
      i_wake_pin = 1'b0;
   endtask
   task t_run;
      `CHK("lvd", 1'b1, o_ctrl.lvd_en)
      i_reduced_speed_run = 1'b1;
      i_dcdc_continuous = 1'b1;
      repeat (2) @(negedge i_sys_clk);
      `CHK("bias_run", 1'b0, o_ctrl.bias_en)
      i_reduced_speed_run = 1'b0;
   endtask
   task t_wait;
      go(3'h3, 1'b0);
      `CHK("wait", lpmc_pkg::LPMC_WAIT, o_state)
      wake(1'b1, 1'b0);
      `CHK("wait_run", lpmc_pkg::LPMC_RUN, o_state)
   endtask
   task t_static;
      go(3'h0, 1'b1);
      `CHK("st_stop", lpmc_pkg::LPMC_STOP, o_state)
      `CHK("st_lvd", 1'b0, o_ctrl.lvd_en)
      `CHK("st_adc", 1'b1, o_ctrl.adc_pin_irq_en)
      `CHK("st_bias", 1'b0, o_ctrl.bias_en)
      wake(1'b1, 1'b0);
      `CHK("st_rst", 1'b0, o_wakeup_reset)
   endtask
   task t_ret;
      i_ram_part_32k = 1'b1;
      go(3'h1, 1'b1);
      `CHK("ru_ret", 1'b1, o_ctrl.radio_retain)
      wake(1'b1, 1'b0);
      go(3'h2, 1'b1);
      `CHK("rl_part", 1'b1, o_ctrl.ram_partial)
      `CHK("rl_32k", 1'b1, o_ctrl.ram_part_32k)
      wake(1'b1, 1'b0);
      `CHK("rl_rst", 1'b0, o_wakeup_reset)
   endtask
   task t_leak;
      i_ram_part_32k = 1'b0;
      go(3'h3, 1'b1);
      `CHK("lf_ram", 1'b1, o_ctrl.ram_full)
      wake(1'b1, 1'b0);
      `CHK("lf_rst", 1'b1, o_wakeup_reset)
      go(3'h4, 1'b1);
      `CHK("lp_16k", 1'b0, o_ctrl.ram_part_32k)
      wake(1'b1, 1'b0);
      `CHK("lp_rst", 1'b1, o_wakeup_reset)
   endtask
   task t_noram;
      go(3'h5, 1'b1);
      `CHK("nr_gate", 1'b1, o_ctrl.radio_gated)
      `CHK("nr_reg", 1'b1, o_ctrl.regfile_on)
      wake(1'b1, 1'b0);
      `CHK("nr_lost", 1'b1, o_radio_lost)
   endtask
   task t_deep;
      i_dcdc_bypass = 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         i_deep_bod_en = k[0];
         go(3'h6, 1'b1);
         `CHK("dp_lpo", 1'b0, o_ctrl.lpo_en)
         `CHK("dp_bod", k[0], o_ctrl.bod_en)
         wake(1'b1, 1'b0);
         `CHK("dp_irq", lpmc_pkg::LPMC_STOP, o_state)
         wake(1'b0, 1'b1);
         `CHK("dp_pin", lpmc_pkg::LPMC_RUN, o_state)
      end
   endtask
   task t_refuse;
      i_dcdc_bypass = 1'b0;
      go(3'h6, 1'b1);
      `CHK("rf_flag", 1'b1, o_sel_refused)
      wake(1'b1, 1'b0);
      `CHK("rf_run", lpmc_pkg::LPMC_RUN, o_state)
      i_rstn = 1'b0;
      @(negedge i_sys_clk);
      i_rstn = 1'b1;
      `CHK("rs_lost", 1'b0, o_radio_lost)
   endtask
   // reset then scenarios
   initial
   begin
      repeat (2) @(negedge i_sys_clk);
      i_rstn = 1'b1;
      t_run();
      t_wait();
      t_static();
      t_ret();
      t_leak();
      t_noram();
      t_deep();
      t_refuse();
      close_out();
   end
   // watchdog
   initial
   begin
      #100000;
      failures++;
      close_out();
   end
endmodule // lpmc_ctrl_tb
`default_nettype wire
